// ---- src/gpl_port.sv ----
`timescale 1ns/1ps
module gpl_port import gpl_pkg::*; #(
  parameter bit PORT_A   = 1'b1,
  parameter bit HAS_LOCK = 1'b1
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          periph_rst,
  input  wire gpl_axil_req_t req,
  output gpl_axil_rsp_t      rsp,
  input  wire logic [15:0]   pin_in,
  output logic      [15:0]   out_level,
  output logic      [15:0]   pull_up_en,
  output logic      [15:0]   pull_dn_en,
  output logic      [31:0]   alt_sel,
  output logic      [15:0]   pin_frozen,
  output logic               key_active
);
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] pull;
    logic [15:0] pup;
    logic [15:0] pdn;
    logic [15:0] odata;
    logic [31:0] alt;
    logic [15:0] freeze;
    logic [15:0] frz;
    gpl_lock_t   lk;
    logic        key;
  } gpl_st_t;

  gpl_st_t     q;
  gpl_st_t     n;
  logic [15:0] pin_lvl;
  logic        srst;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_wr;
  logic        lk_rd;
  gpl_reg_t    wsel;
  gpl_reg_t    rsel;
  logic [31:0] m;
  logic [31:0] wd;
  logic [31:0] merged;
  logic        same;

  assign srst = rst | periph_rst;

  // pin sampling
  gpl_pin_sync #(
    .W (NPIN)
  ) gpl_pin_sync_inst (
    .ref_clk (ref_clk),
    .rst     (srst),
    .pin_in  (pin_in),
    .level   (pin_lvl)
  );

  // bus handshakes and register updates
  always_comb begin
    n = q;
    aw_hs = req.awvalid & q.awready;
    w_hs = req.wvalid & q.wready;
    ar_hs = req.arvalid & q.arready;
    if (aw_hs) begin
      n.aw_full = 1'b1;
      n.awaddr = req.awaddr;
    end
    if (w_hs) begin
      n.w_full = 1'b1;
      n.wdata = req.wdata;
      n.wstrb = req.wstrb;
    end
    if (q.bvalid & req.bready) begin
      n.bvalid = 1'b0;
    end
    if (q.rvalid & req.rready) begin
      n.rvalid = 1'b0;
    end
    do_wr = n.aw_full & n.w_full & ~q.bvalid;
    wsel = gpl_decode(n.awaddr);
    m = gpl_bmask(n.wstrb);
    wd = n.wdata & m;
    merged = (q.alt & ~m) | wd;
    same = (wd[15:0] == q.freeze);
    rsel = gpl_decode(req.araddr);
    lk_rd = ar_hs & HAS_LOCK & (rsel == RI_LOCK);
    if (do_wr) begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wsel == RI_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (wsel)
        RI_PULL: begin
          for (int i = 0; i < NPIN; i++) begin
            if (!q.frz[i]) begin
              n.pull[2*i +: 2] = (q.pull[2*i +: 2] & ~m[2*i +: 2]) | wd[2*i +: 2];
            end
          end
        end
        RI_OUT: n.odata = (q.odata & ~m[15:0]) | wd[15:0];
        RI_BSC: n.odata = (q.odata & ~wd[31:16]) | wd[15:0];
        RI_CLR: n.odata = q.odata & ~wd[15:0];
        RI_LOCK: begin
          if (HAS_LOCK && q.lk != LK_DONE) begin
            n.freeze = wd[15:0];
            // mismatch in key or mask drops the sequence
            n.lk = wd[KEY_BIT] ? LK_ONE : LK_IDLE;
            case (q.lk)
              LK_ONE: if (!wd[KEY_BIT] && same) n.lk = LK_ZERO;
              LK_ZERO: if (wd[KEY_BIT] && same) n.lk = LK_AGAIN;
              default: ;
            endcase
          end
        end
        RI_ALTL: begin
          for (int i = 0; i < NALT; i++) begin
            if (!q.frz[i] && merged[4*i +: 4] <= AF_LAST) begin
              n.alt[4*i +: 4] = merged[4*i +: 4];
            end
          end
        end
        default: ;
      endcase
    end
    // read of the lock register completes or aborts the sequence
    if (lk_rd) begin
      case (q.lk)
        LK_AGAIN: n.lk = LK_DONE;
        LK_ONE, LK_ZERO: n.lk = LK_IDLE;
        default: ;
      endcase
    end
    if (ar_hs) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (rsel)
        RI_PULL: n.rdata = q.pull;
        RI_IN:   n.rdata = {16'h0000, pin_lvl};
        RI_OUT:  n.rdata = {16'h0000, q.odata};
        RI_LOCK: n.rdata = HAS_LOCK ? {15'h0000, q.key, q.freeze} : 32'h0000_0000;
        RI_ALTL: n.rdata = q.alt;
        RI_NONE: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    n.awready = ~n.aw_full;
    n.wready = ~n.w_full;
    n.arready = ~n.rvalid;
    n.key = (n.lk == LK_DONE);
    n.frz = n.key ? n.freeze : 16'h0000;
    for (int i = 0; i < NPIN; i++) begin
      n.pup[i] = (n.pull[2*i +: 2] == PULL_UP);
      n.pdn[i] = (n.pull[2*i +: 2] == PULL_DN);
    end
  end

  // state register; peripheral reset acts like system reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
      q.pull <= PORT_A ? PULL_RST_A : PULL_RST_OTH;
      q.pup <= PORT_A ? {PULL_RST_A[31:30] == PULL_UP, PULL_RST_A[29:28] == PULL_UP,
                         PULL_RST_A[27:26] == PULL_UP, 13'h0000} : 16'h0000;
      q.pdn <= PORT_A ? {PULL_RST_A[31:30] == PULL_DN, PULL_RST_A[29:28] == PULL_DN,
                         PULL_RST_A[27:26] == PULL_DN, 13'h0000} : 16'h0000;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from state
  assign rsp.awready = q.awready;
  assign rsp.wready = q.wready;
  assign rsp.bresp = q.bresp;
  assign rsp.bvalid = q.bvalid;
  assign rsp.arready = q.arready;
  assign rsp.rdata = q.rdata;
  assign rsp.rresp = q.rresp;
  assign rsp.rvalid = q.rvalid;
  assign out_level = q.odata;
  assign pull_up_en = q.pup;
  assign pull_dn_en = q.pdn;
  assign alt_sel = q.alt;
  assign pin_frozen = q.frz;
  assign key_active = q.key;

  // checks; frozen pins spread over their field bits
  logic [31:0] frz2;
  logic [31:0] frz4;
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      frz2[2*i +: 2] = {2{q.frz[i]}};
    end
    for (int i = 0; i < NALT; i++) begin
      frz4[4*i +: 4] = {4{q.frz[i]}};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_bsc_set_wins: assert property (do_wr && wsel == RI_BSC |=>
    ((q.odata & $past(wd[15:0])) == $past(wd[15:0])))
    else $error("set bit did not set output");
  chk_bsc_clear_bit: assert property (do_wr && wsel == RI_BSC |=>
    ((q.odata & $past(wd[31:16] & ~wd[15:0])) == 16'h0000))
    else $error("clear bit did not clear output");
  chk_clr_only_bit: assert property (do_wr && wsel == RI_CLR |=>
    ((q.odata & $past(wd[15:0])) == 16'h0000))
    else $error("clear-only write did not clear output");
  chk_wo_reads_zero: assert property (ar_hs && (rsel == RI_BSC || rsel == RI_CLR) |=>
    (rsp.rvalid && rsp.rdata == 32'h0000_0000))
    else $error("write-only register read nonzero");
  chk_key_sticky: assert property (q.lk == LK_DONE |=> q.lk == LK_DONE ##1 key_active)
    else $error("freeze key dropped");
  chk_key_complete: assert property (q.lk == LK_AGAIN && lk_rd |=> key_active)
    else $error("good key sequence did not activate");
  chk_key_abort: assert property (q.lk == LK_ONE && do_wr && wsel == RI_LOCK && !same
    && !lk_rd |=> q.lk inside {LK_IDLE, LK_ONE})
    else $error("changed mask did not abort");
  chk_frozen_pull: assert property (do_wr && wsel == RI_PULL |=>
    (((q.pull ^ $past(q.pull)) & $past(frz2)) == 32'h0000_0000))
    else $error("frozen pull field changed");
  chk_pull_none: assert property ((pull_up_en & pull_dn_en) == 16'h0000)
    else $error("pull up and down both on");
  chk_input_level: assert property ((pin_in == $past(pin_in)) [*6] |=>
    (pin_lvl == $past(pin_in, 2)))
    else $error("input level not sampled");

  // set/clear and clear-only writes leave other bits alone; full direct writes land
  chk_bsc_keep_rest: assert property (do_wr && wsel == RI_BSC |=>
    (((q.odata ^ $past(q.odata)) & ~$past(wd[15:0] | wd[31:16])) == 16'h0000))
    else $error("set/clear write touched other bits");
  chk_clr_keep_rest: assert property (do_wr && wsel == RI_CLR |=>
    (((q.odata ^ $past(q.odata)) & ~$past(wd[15:0])) == 16'h0000))
    else $error("clear-only write touched other bits");
  chk_out_direct: assert property (do_wr && wsel == RI_OUT && m[15:0] == 16'hFFFF |=>
    (out_level == $past(wd[15:0])))
    else $error("direct output write lost");
  chk_out_upper_zero: assert property (ar_hs && rsel == RI_OUT |=>
    (rsp.rdata[31:16] == 16'h0000))
    else $error("output level upper half nonzero");
  chk_in_upper_zero: assert property (ar_hs && rsel == RI_IN |=>
    (rsp.rdata[31:16] == 16'h0000 && rsp.rdata[15:0] == $past(pin_lvl)))
    else $error("input level read wrong");

  // freeze key and freeze bits
  chk_freeze_writable: assert property (HAS_LOCK && !key_active && do_wr && wsel == RI_LOCK
    && m[15:0] == 16'hFFFF |=> q.freeze == $past(wd[15:0]))
    else $error("freeze bits not written while key off");
  chk_key_locks_reg: assert property (key_active && do_wr && wsel == RI_LOCK |=>
    (key_active && $stable(pin_frozen)))
    else $error("lock register changed after activation");
  chk_key_reads_one: assert property (key_active && ar_hs && rsel == RI_LOCK |=>
    rsp.rdata[KEY_BIT])
    else $error("active key read as zero");
  chk_lock_reserved: assert property (ar_hs && rsel == RI_LOCK |=>
    (rsp.rdata[31:17] == 15'h0000))
    else $error("lock register reserved bits nonzero");
  chk_key_read_abort: assert property ((q.lk == LK_ONE || q.lk == LK_ZERO) && lk_rd |=>
    (q.lk == LK_IDLE))
    else $error("early lock read did not abort");
  chk_frozen_needs_key: assert property (|pin_frozen |-> key_active)
    else $error("pins frozen without key");
  chk_no_lock_port: assert property (!HAS_LOCK |-> !key_active && pin_frozen == 16'h0000)
    else $error("freeze active on a port without lock");

  // alternate function fields
  chk_alt_reserved: assert property ((alt_sel & 32'h8888_8888) == 32'h0000_0000)
    else $error("reserved alternate code stored");
  chk_frozen_alt: assert property (do_wr && wsel == RI_ALTL |=>
    (((q.alt ^ $past(q.alt)) & $past(frz4)) == 32'h0000_0000))
    else $error("frozen alternate field changed");
  chk_alt_takes: assert property (do_wr && wsel == RI_ALTL && m == 32'hFFFF_FFFF
    && q.frz[7:0] == 8'h00 && (wd & 32'h8888_8888) == 32'h0000_0000
    |=> alt_sel == $past(wd))
    else $error("alternate select write lost");

  // pull codes decoded per pin
  for (genvar g = 0; g < NPIN; g++) begin : g_pull_chk
    chk_pull_code: assert property (@(posedge ref_clk) disable iff (srst)
      do_wr && wsel == RI_PULL && m[2*g +: 2] == 2'h3 && !q.frz[g]
      |=> pull_up_en[g] == ($past(wd[2*g +: 2]) == PULL_UP)
      && pull_dn_en[g] == ($past(wd[2*g +: 2]) == PULL_DN))
      else $error("pull code decoded wrongly");
  end

  // unmapped addresses answer with an error
  chk_unmapped_read: assert property (ar_hs && rsel == RI_NONE |=>
    (rsp.rresp == RESP_SLVERR && rsp.rdata == 32'h0000_0000))
    else $error("unmapped read not refused");
  chk_unmapped_write: assert property (do_wr && wsel == RI_NONE |=>
    (rsp.bvalid && rsp.bresp == RESP_SLVERR))
    else $error("unmapped write not refused");

  // main scenarios reached
  cov_lock_done: cover property (q.lk == LK_AGAIN ##1 q.lk == LK_DONE);
  cov_bsc_both: cover property (do_wr && wsel == RI_BSC && |(wd[31:16] & wd[15:0]));
  cov_frozen_write: cover property (do_wr && wsel == RI_PULL && |q.frz);
  cov_key_abort: cover property (q.lk == LK_ONE ##1 q.lk == LK_IDLE);
  cov_alt_reserved: cover property (do_wr && wsel == RI_ALTL && |(wd & 32'h8888_8888));
endmodule // gpl_port

// ---- src/gpl_pkg.sv ----
package gpl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_PULL = 8'h0C;
  localparam logic [7:0] OFS_IN   = 8'h10;
  localparam logic [7:0] OFS_OUT  = 8'h14;
  localparam logic [7:0] OFS_BSC  = 8'h18;
  localparam logic [7:0] OFS_LOCK = 8'h1C;
  localparam logic [7:0] OFS_ALTL = 8'h20;
  localparam logic [7:0] OFS_CLR  = 8'h28;
  // field positions
  localparam int NPIN    = 16;
  localparam int KEY_BIT = 16;
  localparam int NALT    = 8;
  // reset values
  localparam logic [31:0] PULL_RST_A   = 32'h2400_0000;
  localparam logic [31:0] PULL_RST_OTH = 32'h0000_0000;
  // pull codes, alternate function limit
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DN = 2'h2;
  localparam logic [3:0] AF_LAST = 4'h7;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    LK_IDLE  = 3'h0,
    LK_ONE   = 3'h1,
    LK_ZERO  = 3'h3,
    LK_AGAIN = 3'h2,
    LK_DONE  = 3'h6
  } gpl_lock_t;

  typedef enum logic [2:0] {
    RI_PULL, RI_IN, RI_OUT, RI_BSC, RI_LOCK, RI_ALTL, RI_CLR, RI_NONE
  } gpl_reg_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } gpl_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } gpl_axil_rsp_t;

  // byte address to register
  function automatic gpl_reg_t gpl_decode(input logic [7:0] a);
    case (a)
      OFS_PULL: gpl_decode = RI_PULL;
      OFS_IN:   gpl_decode = RI_IN;
      OFS_OUT:  gpl_decode = RI_OUT;
      OFS_BSC:  gpl_decode = RI_BSC;
      OFS_LOCK: gpl_decode = RI_LOCK;
      OFS_ALTL: gpl_decode = RI_ALTL;
      OFS_CLR:  gpl_decode = RI_CLR;
      default:  gpl_decode = RI_NONE;
    endcase
  endfunction

  // byte strobes to bit mask
  function automatic logic [31:0] gpl_bmask(input logic [3:0] s);
    gpl_bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
endpackage

// ---- src/gpl_pin_sync.sv ----
`timescale 1ns/1ps
module gpl_pin_sync import gpl_pkg::*; #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } gpl_sync_st_t;

  gpl_sync_st_t q;
  gpl_sync_st_t n;

  // three stages; a bit counts once stages two and three agree
  always_comb begin
    n = q;
    n.s1 = pin_in;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.lvl = (q.lvl & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign level = q.lvl;
endmodule // gpl_pin_sync

// ---- verification/gpl_port_data_lock_regs_bench.sv ----
`timescale 1ns/1ps
module gpl_port_data_lock_regs_bench import gpl_pkg::*;;
  logic          ref_clk;
  logic          rst;
  logic          periph_rst;
  gpl_axil_req_t req;
  gpl_axil_rsp_t rsp;
  logic [15:0]   pin_in;
  logic [15:0]   out_level;
  logic [15:0]   pull_up_en;
  logic [15:0]   pull_dn_en;
  logic [31:0]   alt_sel;
  logic [15:0]   pin_frozen;
  logic          key_active;
  gpl_axil_rsp_t rsp_b;
  logic [15:0]   pull_up_en_b;
  logic [15:0]   pull_dn_en_b;
  logic [15:0]   pin_frozen_b;
  logic          key_active_b;
  logic [1:0]    last_resp;
  logic [31:0]   rd;
  int            err_count;
  int            check_count;

  gpl_port gpl_port_inst (
    .ref_clk(ref_clk), .rst(rst), .periph_rst(periph_rst), .req(req), .rsp(rsp),
    .pin_in(pin_in), .out_level(out_level), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .alt_sel(alt_sel), .pin_frozen(pin_frozen),
    .key_active(key_active)
  );

  // a port other than A, built without the freeze
  gpl_port #(
    .PORT_A   (1'b0),
    .HAS_LOCK (1'b0)
  ) gpl_port_b_inst (
    .ref_clk(ref_clk), .rst(rst), .periph_rst(periph_rst), .req(req), .rsp(rsp_b),
    .pin_in(pin_in), .out_level(), .pull_up_en(pull_up_en_b),
    .pull_dn_en(pull_dn_en_b), .alt_sel(), .pin_frozen(pin_frozen_b),
    .key_active(key_active_b)
  );

  // clock, 25 ns period
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // counts then verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // bus write, address and data offered together; outputs looked at mid-cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic b;
    logic aw_go;
    logic w_go;
    b = 1'b0;
    n = 0;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    while (!b && n < 100) begin
      @(negedge ref_clk);
      aw_go = req.awvalid && rsp.awready === 1'b1;
      w_go  = req.wvalid && rsp.wready === 1'b1;
      b     = rsp.bvalid === 1'b1;
      if (b) last_resp = rsp.bresp;
      @(posedge ref_clk);
      n++;
      if (aw_go) req.awvalid <= 1'b0;
      if (w_go) req.wvalid <= 1'b0;
    end
    if (!b) chk(32'hDEAD_0001, 32'h0);
  endtask

  // bus read; outputs looked at mid-cycle, where they are settled
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    int   n;
    logic b;
    logic ar_go;
    b = 1'b0;
    n = 0;
    d = 32'h0;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    while (!b && n < 100) begin
      @(negedge ref_clk);
      ar_go = req.arvalid && rsp.arready === 1'b1;
      b     = rsp.rvalid === 1'b1;
      if (b) begin
        d = rsp.rdata;
        last_resp = rsp.rresp;
      end
      @(posedge ref_clk);
      n++;
      if (ar_go) req.arvalid <= 1'b0;
    end
    if (!b) chk(32'hDEAD_0002, 32'h0);
  endtask

  // reset values of the map
  task automatic t_reset();
    rdr(OFS_PULL, rd); chk(rd, PULL_RST_A);
    chk(rsp_b.rdata, PULL_RST_OTH);
    chk({pull_dn_en_b, pull_up_en_b}, 32'h0);
    chk({pull_dn_en, pull_up_en}, 32'h4000_2000);
    rdr(OFS_OUT, rd); chk(rd, 32'h0);
    rdr(OFS_LOCK, rd); chk(rd, 32'h0);
    rdr(OFS_ALTL, rd); chk(rd, 32'h0);
  endtask

  // pull codes including the unusable one
  task automatic t_pull();
    wr(OFS_PULL, 32'h0000_00E4); chk(last_resp, RESP_OKAY);
    chk(pull_up_en, 32'h0002);
    chk(pull_dn_en, 32'h0004);
  endtask

  // direct, set/clear and clear-only output writes
  task automatic t_out();
    wr(OFS_OUT, 32'hFFFF_A5A5);
    rdr(OFS_OUT, rd); chk(rd, 32'h0000_A5A5);
    wr(OFS_BSC, 32'h0001_0002); chk(out_level, 32'hA5A6);
    wr(OFS_BSC, 32'h0008_0008); chk(out_level, 32'hA5AE);
    wr(OFS_CLR, 32'hFFFF_00F0); chk(out_level, 32'hA50E);
    req.wstrb <= 4'h1;
    wr(OFS_OUT, 32'h0000_FFFF); chk(out_level, 32'hA5FF);
    req.wstrb <= 4'hF;
    rdr(OFS_BSC, rd); chk(rd, 32'h0);
    rdr(OFS_CLR, rd); chk(rd, 32'h0);
  endtask

  // sampled pin levels
  task automatic t_in();
    pin_in <= 16'h3C5A;
    repeat (8) @(posedge ref_clk);
    rdr(OFS_IN, rd); chk(rd, 32'h0000_3C5A);
  endtask

  // alternate select with reserved codes and unmapped places
  task automatic t_alt();
    wr(OFS_ALTL, 32'h7654_3211); chk(alt_sel, 32'h7654_3211);
    wr(OFS_ALTL, 32'h0765_4328);
    rdr(OFS_ALTL, rd); chk(rd, 32'h0765_4321);
    rdr(8'h04, rd); chk({last_resp, rd[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h24, 32'h1); chk(last_resp, RESP_SLVERR);
  endtask

  // broken key sequence, then good one, then freeze effects
  task automatic t_lock();
    wr(OFS_LOCK, 32'h0001_0003);
    wr(OFS_LOCK, 32'h0000_0001);
    wr(OFS_LOCK, 32'h0001_0001);
    rdr(OFS_LOCK, rd);
    rdr(OFS_LOCK, rd); chk(rd, 32'h0000_0001);
    chk(key_active, 32'h0);
    wr(OFS_LOCK, 32'h0001_0003);
    wr(OFS_LOCK, 32'h0000_0003);
    wr(OFS_LOCK, 32'h0001_0003);
    rdr(OFS_LOCK, rd);
    rdr(OFS_LOCK, rd); chk(rd, 32'h0001_0003);
    chk({key_active, pin_frozen}, 32'h1_0003);
    chk(rsp_b.rdata, 32'h0);
    chk({key_active_b, pin_frozen_b}, 32'h0);
    wr(OFS_LOCK, 32'h0000_0000);
    rdr(OFS_LOCK, rd); chk(rd, 32'h0001_0003);
    wr(OFS_PULL, 32'h0);
    rdr(OFS_PULL, rd); chk(rd, 32'h0000_0004);
    wr(OFS_ALTL, 32'h0);
    rdr(OFS_ALTL, rd); chk(rd, 32'h0000_0021);
    wr(OFS_OUT, 32'h0000_1234); chk(out_level, 32'h1234);
  endtask

  // peripheral reset drops the key
  task automatic t_prst();
    periph_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    periph_rst <= 1'b0;
    @(posedge ref_clk);
    rdr(OFS_LOCK, rd); chk(rd, 32'h0);
    chk(key_active, 32'h0);
  endtask

  // watchdog
  initial begin
    #(25 * 20000);
    err_count++;
    stop_test();
  end

  // main sequence
  initial begin
    err_count = 0;
    check_count = 0;
    rst = 1'b1;
    periph_rst = 1'b0;
    pin_in = 16'h0;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_pull();
    t_out();
    t_in();
    t_alt();
    t_lock();
    t_prst();
    stop_test();
  end
endmodule // gpl_port_data_lock_regs_bench
